// ==== memphy_late_calibration_tracking_test.sv ====
`timescale 1ns/1ns
module memphy_late_calibration_tracking_test;
  import mlct_pkg::*;
  localparam int unsigned TRK = 200;
  localparam logic [7:0] WLS = 8'h05;
  localparam logic [4:0] POK = 5'h1c;
  logic clk, resetn, cal_start, dqs_capture, half_rate, cal_done, cal_fail, restart_cal;
  logic cmd_valid, cmd_ready, cmd_write, doing_rd, rd_valid, mr_valid, mr_ready, mr_user;
  logic pll_req, pll_sel_resync, pll_up, pll_done, mimic_sample, addr_cmd_1t;
  logic slow, misalign, poa_en;
  logic [ADDR_W-1:0] cmd_addr;
  logic [DATA_W-1:0] cmd_wdata, rd_data;
  logic [CS_W-1:0] mr_cs;
  logic [CNT_W-1:0] read_latency;
  logic [BEAT_W-1:0] write_latency_cycles;
  logic [4:0] poa_delay;
  logic [3:0] mimic_lo;
  int miscompares = 0;
  int n_checks = 0;
  int n_up, n_dn, n_rst, n_poa;
  logic [7:0] mr_log;

  mlct_seq #(.TRACK_CYCLES(TRK)) mlct_seq_inst (.clk(clk), .resetn(resetn),
    .cal_start(cal_start), .dqs_capture(dqs_capture), .half_rate(half_rate),
    .cal_done(cal_done), .cal_fail(cal_fail), .restart_cal(restart_cal),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .doing_rd(doing_rd), .rd_valid(rd_valid), .rd_data(rd_data),
    .mr_valid(mr_valid), .mr_ready(mr_ready), .mr_cs(mr_cs), .mr_user(mr_user),
    .pll_req(pll_req), .pll_sel_resync(pll_sel_resync), .pll_up(pll_up), .pll_done(pll_done),
    .mimic_sample(mimic_sample), .read_latency(read_latency),
    .write_latency_cycles(write_latency_cycles), .addr_cmd_1t(addr_cmd_1t),
    .poa_delay(poa_delay));

  mlct_mem_model #(.RD_LAT(3), .WL_SHIFT(WLS)) mlct_mem_model_inst (.clk(clk),
    .resetn(resetn), .slow(slow), .misalign(misalign), .poa_en(poa_en), .poa_ok(POK),
    .mimic_lo(mimic_lo), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rd_valid(rd_valid),
    .rd_data(rd_data), .mr_valid(mr_valid), .mr_ready(mr_ready), .pll_req(pll_req),
    .pll_sel_resync(pll_sel_resync), .pll_done(pll_done), .mimic_sample(mimic_sample),
    .addr_cmd_1t(addr_cmd_1t), .poa_delay(poa_delay));

  // ----------------------------------------
  // Clock and event counters
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (pll_req && pll_done && pll_sel_resync && pll_up) n_up++;
    if (pll_req && pll_done && pll_sel_resync && !pll_up) n_dn++;
    if (restart_cal) n_rst++;
    if (mr_valid && mr_ready) mr_log = {mr_log[5:0], 1'b1, mr_cs};
    if (cmd_valid && cmd_ready && !cmd_write && cmd_addr == POA_ADDR) n_poa++;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic run(input logic dqs, input logic hr, input logic mis, input logic pen,
                     input logic slw);
    @(posedge clk);
    resetn <= 1'b0;
    slow <= slw;
    dqs_capture <= dqs;
    half_rate <= hr;
    misalign <= mis;
    poa_en <= pen;
    mimic_lo <= 4'h3;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    n_up = 0;
    n_dn = 0;
    n_rst = 0;
    n_poa = 0;
    mr_log = 8'h00;
    @(posedge clk);
    cal_start <= 1'b1;
    @(posedge clk);
    cal_start <= 1'b0;
    for (int i = 0; i < 20000 && !cal_done && !cal_fail; i++) @(posedge clk);
    #1;
  endtask : run

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(poa_delay, 5'h1f);
    chk({cal_done, cal_fail, addr_cmd_1t, pll_up, mr_user}, 5'h03);
    chk(read_latency, 8'h00);
  endtask : t_reset

  task automatic t_basic;
    run(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    chk(mr_log, 8'h0b);
    chk({cal_done, cal_fail, addr_cmd_1t}, 3'h4);
    chk(read_latency, 8'h03);
    chk(write_latency_cycles, WLS);
    chk(poa_delay, POK);
    chk(n_poa, 32'h1f - POK + 1);
  endtask : t_basic

  task automatic t_retry;
    run(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    chk({cal_done, cal_fail, addr_cmd_1t}, 3'h5);
    chk(n_rst, 1);
    chk(write_latency_cycles, WLS);
  endtask : t_retry

  task automatic t_nohr;
    run(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    chk({cal_fail, addr_cmd_1t}, 2'h2);
    chk(n_rst, 0);
  endtask : t_nohr

  task automatic t_skip;
    run(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    chk(n_poa, 0);
    chk(poa_delay, 5'h1f);
    chk(cal_done, 1'b1);
  endtask : t_skip

  task automatic t_poafail;
    run(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    chk({cal_done, cal_fail}, 2'h1);
    chk(poa_delay, 5'h00);
    chk(n_poa, 32);
  endtask : t_poafail

  task automatic t_track;
    run(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    @(posedge clk);
    mimic_lo <= 4'h5;
    repeat (TRK - 10) @(posedge clk);
    chk(n_up + n_dn, 0);
    for (int i = 0; i < 1000 && n_up < 2; i++) @(posedge clk);
    repeat (20) @(posedge clk);
    chk(n_up, 32'd2);
    chk(n_dn, 32'd0);
    mimic_lo <= 4'h4;
    for (int i = 0; i < 1000 && n_dn < 1; i++) @(posedge clk);
    repeat (TRK + 200) @(posedge clk);
    // Drift already applied must not be applied again
    chk(n_up, 32'd2);
    chk(n_dn, 32'd1);
  endtask : t_track

  initial begin
    #200000;
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end

  initial begin
    resetn = 1'b0;
    cal_start = 1'b0;
    dqs_capture = 1'b1;
    half_rate = 1'b0;
    slow = 1'b0;
    misalign = 1'b0;
    poa_en = 1'b1;
    mimic_lo = 4'h3;
    t_reset();
    t_basic();
    t_retry();
    t_nohr();
    t_skip();
    t_poafail();
    t_track();
    test_done();
  end
endmodule : memphy_late_calibration_tracking_test

// ==== mlct_counter.sv ====
`timescale 1ns/1ns
module mlct_counter #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic clr,
  input wire logic en,
  // Count
  output logic [W-1:0] cnt
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (clr) begin
      cnt_next = '0;
    end else if (en) begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign cnt = cnt_reg;

endmodule : mlct_counter

// ==== mlct_mem_model.sv ====
`timescale 1ns/1ns
module mlct_mem_model
  import mlct_pkg::*;
#(
  parameter int RD_LAT = 3,
  parameter logic [7:0] WL_SHIFT = 8'h05
) (
  // Clock, reset and scenario knobs
  input wire logic clk,
  input wire logic resetn,
  input wire logic slow,
  input wire logic misalign,
  input wire logic poa_en,
  input wire logic [4:0] poa_ok,
  input wire logic [3:0] mimic_lo,
  // Sequencer side
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_wdata,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  input wire logic mr_valid,
  output logic mr_ready,
  input wire logic pll_req,
  input wire logic pll_sel_resync,
  output logic pll_done,
  output logic mimic_sample,
  input wire logic addr_cmd_1t,
  input wire logic [4:0] poa_delay
);
  logic [DATA_W-1:0] mem [0:255];
  logic [DATA_W-1:0] dq [0:RD_LAT-2];
  logic vq [0:RD_LAT-2];
  logic tick, d_reg;
  logic [3:0] tap;

  function automatic logic [DATA_W-1:0] rd_word(input logic [ADDR_W-1:0] a);
    if (a == POA_ADDR)
      return (poa_en && poa_delay <= poa_ok) ? POA_PASS : 32'h00000000;
    if (a == WL_ADDR_FIRST && misalign && !addr_cmd_1t)
      return mem[a] ^ 32'h01000000;
    return mem[a];
  endfunction : rd_word

  // Reads may stall; writes never do, so the count pattern stays predictable
  assign cmd_ready = cmd_write | ~slow | tick;
  assign mimic_sample = (tap - mimic_lo) < 4'h5;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick <= 1'b0;
      d_reg <= 1'b0;
      pll_done <= 1'b0;
      mr_ready <= 1'b0;
      tap <= 4'h0;
      rd_valid <= 1'b0;
      rd_data <= 32'h00000000;
      for (int i = 0; i < RD_LAT - 1; i++) vq[i] <= 1'b0;
      // Cleared here so only one process ever writes the array
      for (int i = 0; i < 256; i++) mem[i] <= 32'h00000000;
    end else begin
      tick <= ~tick;
      d_reg <= pll_req & ~pll_done & ~d_reg;
      pll_done <= d_reg;
      mr_ready <= mr_valid & ~mr_ready;
      if (pll_done && !pll_sel_resync) tap <= tap + 4'h1;
      if (cmd_valid && cmd_ready && cmd_write) mem[cmd_addr - WL_SHIFT] <= cmd_wdata;
      vq[0] <= cmd_valid & cmd_ready & ~cmd_write;
      dq[0] <= rd_word(cmd_addr);
      for (int i = 1; i < RD_LAT - 1; i++) begin
        vq[i] <= vq[i-1];
        dq[i] <= dq[i-1];
      end
      rd_valid <= vq[RD_LAT-2];
      // Idle data line keeps moving so stale words never look valid
      rd_data <= vq[RD_LAT-2] ? dq[RD_LAT-2] : ~rd_data;
    end
  end
endmodule : mlct_mem_model

// ==== mlct_phase_center.sv ====
`timescale 1ns/1ns
module mlct_phase_center
  import mlct_pkg::*;
(
  // Swept mimic samples, bit i taken at phase tap i
  input wire logic [NUM_PHASE-1:0] samples,
  // Tap at the middle of the high period
  output logic [PH_W-1:0] center
);

  logic [PH_W-1:0] rise;
  logic [PH_W-1:0] fall;
  logic [PH_W-1:0] len;

  // Circular search; a flat waveform yields tap 0
  always_comb begin
    rise = '0;
    fall = '0;
    for (int i = 0; i < NUM_PHASE; i++) begin
      if (samples[i] && !samples[(i + NUM_PHASE - 1) % NUM_PHASE]) begin
        rise = PH_W'(i);
      end
      if (!samples[i] && samples[(i + NUM_PHASE - 1) % NUM_PHASE]) begin
        fall = PH_W'(i);
      end
    end
    len = fall - rise;
    center = rise + (len >> 1);
  end

endmodule : mlct_phase_center

// ==== mlct_pkg.sv ====
package mlct_pkg;

  // ----------------------------------------
  // Clock and tracking interval
  // ----------------------------------------
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned TRACK_MS = 128;
  localparam int unsigned TRACK_CYC = TRACK_MS * 1000 * CLK_MHZ;
  localparam int unsigned TMR_W = 25;

  // ----------------------------------------
  // Datapath shape
  // ----------------------------------------
  localparam int unsigned BEAT_W = 8;
  localparam int unsigned BEATS = 4;
  localparam int unsigned DATA_W = BEAT_W * BEATS;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned NUM_CS = 2;
  localparam int unsigned CS_W = 1;
  localparam int unsigned NUM_PHASE = 16;
  localparam int unsigned PH_W = 4;
  localparam int unsigned IDX_W = 4;

  // ----------------------------------------
  // Memory locations and patterns
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] WL_ADDR_FIRST = 8'h30;
  localparam logic [ADDR_W-1:0] WL_ADDR_PRE = 8'h2f;
  localparam logic [ADDR_W-1:0] WL_ADDR_POST = 8'h38;
  localparam logic [IDX_W-1:0] WL_WORDS_LAST = 4'h7;
  localparam logic [ADDR_W-1:0] POA_ADDR = 8'h40;
  localparam logic [BEAT_W-1:0] POA_PATTERN = 8'h30;
  localparam logic [DATA_W-1:0] POA_PASS = 32'hffffffff;

  // ----------------------------------------
  // Calibration limits and reset values
  // ----------------------------------------
  localparam logic [CNT_W-1:0] MAX_RLAT_CYC = 8'h20;
  localparam logic [4:0] POA_DLY_MAX = 5'h1f;
  localparam logic [1:0] AC1T_TRIES = 2'h2;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [15:0] {
    S_IDLE = 16'h0001,
    S_POA_RD = 16'h0002,
    S_POA_CHK = 16'h0004,
    S_WAS = 16'h0008,
    S_WAIT = 16'h0010,
    S_RLAT = 16'h0020,
    S_RLAT_W = 16'h0040,
    S_AL_RD = 16'h0080,
    S_AL_W = 16'h0100,
    S_CHK = 16'h0200,
    S_MR = 16'h0400,
    S_SWEEP = 16'h0800,
    S_STEP = 16'h1000,
    S_CALC = 16'h2000,
    S_ADJ = 16'h4000,
    S_USER = 16'h8000
  } mlct_state_t;

endpackage : mlct_pkg

// ==== mlct_seq.sv ====
`timescale 1ns/1ns
module mlct_seq
  import mlct_pkg::*;
#(
  parameter int unsigned TRACK_CYCLES = TRACK_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Sequencer control
  input wire logic cal_start,
  input wire logic dqs_capture,
  input wire logic half_rate,
  output logic cal_done,
  output logic cal_fail,
  output logic restart_cal,
  // Memory command path
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic cmd_write,
  output logic [ADDR_W-1:0] cmd_addr,
  output logic [DATA_W-1:0] cmd_wdata,
  output logic doing_rd,
  // Read return path
  input wire logic rd_valid,
  input wire logic [DATA_W-1:0] rd_data,
  // Mode register programming
  output logic mr_valid,
  input wire logic mr_ready,
  output logic [CS_W-1:0] mr_cs,
  output logic mr_user,
  // PLL phase stepping
  output logic pll_req,
  output logic pll_sel_resync,
  output logic pll_up,
  input wire logic pll_done,
  input wire logic mimic_sample,
  // Calibrated settings
  output logic [CNT_W-1:0] read_latency,
  output logic [BEAT_W-1:0] write_latency_cycles,
  output logic addr_cmd_1t,
  output logic [4:0] poa_delay
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  mlct_state_t state_reg, state_next;
  logic [IDX_W-1:0] idx_reg, idx_next;
  logic [1:0] rsp_reg, rsp_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] wl_data_reg, wl_data_next;
  logic [CNT_W-1:0] rlat_reg, rlat_next;
  logic [BEAT_W-1:0] wlat_reg, wlat_next;
  logic ac1t_reg, ac1t_next;
  logic [1:0] tries_reg, tries_next;
  logic [4:0] poa_reg, poa_next;
  logic [NUM_PHASE-1:0] smp_reg, smp_next;
  logic [PH_W-1:0] ref_reg, ref_next;
  logic [PH_W-1:0] drift_reg, drift_next;
  logic [PH_W-1:0] adj_reg, adj_next;
  logic adj_up_reg, adj_up_next;
  logic tracked_reg, tracked_next;
  logic done_reg, done_next;
  logic fail_reg, fail_next;
  logic restart_reg, restart_next;

  logic [CNT_W-1:0] lat_cnt;
  logic lat_clr;
  logic lat_en;
  logic [TMR_W-1:0] tmr_cnt;
  logic [PH_W-1:0] center;
  logic [PH_W-1:0] shift;
  logic beats_equal;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  mlct_counter #(.W(CNT_W)) u_lat_cnt (
    .clk(clk),
    .resetn(resetn),
    .clr(lat_clr),
    .en(lat_en),
    .cnt(lat_cnt)
  );

  // Interval timer, held clear outside user mode
  mlct_counter #(.W(TMR_W)) u_track_tmr (
    .clk(clk),
    .resetn(resetn),
    .clr(state_reg != S_USER),
    .en(state_reg == S_USER),
    .cnt(tmr_cnt)
  );

  mlct_phase_center u_center (
    .samples(smp_reg),
    .center(center)
  );

  // Misalignment mixes neighbouring words into the beats
  assign beats_equal = (wl_data_reg[31:24] == wl_data_reg[23:16]) &&
                       (wl_data_reg[23:16] == wl_data_reg[15:8]) &&
                       (wl_data_reg[15:8] == wl_data_reg[7:0]);

  // Phase error still to be applied
  assign shift = center - ref_reg - drift_reg;

  // Restart the counter on every state change
  assign lat_clr = (state_reg != state_next);
  assign lat_en = (state_reg == S_WAS) || (state_reg == S_WAIT) ||
                  (state_reg == S_RLAT_W);

  // ----------------------------------------
  // Sequencer next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    rsp_next = rsp_reg;
    wl_data_next = wl_data_reg;
    rlat_next = rlat_reg;
    wlat_next = wlat_reg;
    ac1t_next = ac1t_reg;
    tries_next = tries_reg;
    poa_next = poa_reg;
    smp_next = smp_reg;
    ref_next = ref_reg;
    drift_next = drift_reg;
    adj_next = adj_reg;
    adj_up_next = adj_up_reg;
    tracked_next = tracked_reg;
    done_next = done_reg;
    fail_next = fail_reg;
    restart_next = 1'b0;
    unique case (state_reg)
      S_IDLE: begin
        if (cal_start) begin
          done_next = 1'b0;
          fail_next = 1'b0;
          tracked_next = 1'b0;
          tries_next = '0;
          poa_next = POA_DLY_MAX;
          idx_next = '0;
          state_next = dqs_capture ? S_POA_RD : S_WAS;
        end
      end
      S_POA_RD: begin
        if (cmd_ready) begin
          state_next = S_POA_CHK;
        end
      end
      S_POA_CHK: begin
        if (rd_valid) begin
          // Ones held to the end mean no late zeros were captured
          if (rd_data == POA_PASS) begin
            idx_next = '0;
            state_next = S_WAS;
          end else if (poa_reg == '0) begin
            fail_next = 1'b1;
            state_next = S_IDLE;
          end else begin
            poa_next = poa_reg - 1'b1;
            state_next = S_POA_RD;
          end
        end
      end
      S_WAS: begin
        if (cmd_ready) begin
          idx_next = idx_reg + 1'b1;
          if (idx_reg == WL_WORDS_LAST) begin
            state_next = S_WAIT;
          end
        end
      end
      S_WAIT: begin
        if (lat_cnt == MAX_RLAT_CYC) begin
          state_next = S_RLAT;
        end
      end
      S_RLAT: begin
        if (cmd_ready) begin
          state_next = S_RLAT_W;
        end
      end
      S_RLAT_W: begin
        // Returned data is ignored, only its arrival counts
        if (rd_valid) begin
          rlat_next = lat_cnt + 1'b1;
          idx_next = '0;
          rsp_next = '0;
          state_next = S_AL_RD;
        end
      end
      S_AL_RD, S_AL_W: begin
        if (state_reg == S_AL_RD && cmd_ready) begin
          idx_next = idx_reg + 1'b1;
          if (idx_reg == 4'h2) begin
            state_next = S_AL_W;
          end
        end
        if (rd_valid) begin
          rsp_next = rsp_reg + 1'b1;
          if (rsp_reg == 2'h1) begin
            wl_data_next = rd_data;
          end
          if (rsp_reg == 2'h2) begin
            state_next = S_CHK;
          end
        end
      end
      S_CHK: begin
        if (beats_equal) begin
          wlat_next = wl_data_reg[BEAT_W-1:0];
          idx_next = '0;
          state_next = S_MR;
        end else if (half_rate && tries_reg != AC1T_TRIES) begin
          ac1t_next = !ac1t_reg;
          tries_next = tries_reg + 1'b1;
          restart_next = 1'b1;
          idx_next = '0;
          state_next = S_WAS;
        end else begin
          fail_next = 1'b1;
          state_next = S_IDLE;
        end
      end
      S_MR: begin
        if (mr_ready) begin
          idx_next = idx_reg + 1'b1;
          if (idx_reg == IDX_W'(NUM_CS - 1)) begin
            idx_next = '0;
            state_next = S_SWEEP;
          end
        end
      end
      S_SWEEP: begin
        smp_next[idx_reg] = mimic_sample;
        state_next = S_STEP;
      end
      S_STEP: begin
        if (pll_done) begin
          idx_next = idx_reg + 1'b1;
          state_next = (idx_reg == IDX_W'(NUM_PHASE - 1)) ? S_CALC : S_SWEEP;
        end
      end
      S_CALC: begin
        if (!tracked_reg) begin
          ref_next = center;
          drift_next = '0;
          tracked_next = 1'b1;
          done_next = 1'b1;
          state_next = S_USER;
        end else if (shift == '0) begin
          state_next = S_USER;
        end else begin
          // Follow the mimic: top half of the circle is a lag
          adj_up_next = !shift[PH_W-1];
          adj_next = shift[PH_W-1] ? PH_W'(0 - shift) : shift;
          drift_next = drift_reg + shift;
          state_next = S_ADJ;
        end
      end
      S_ADJ: begin
        if (pll_done) begin
          adj_next = adj_reg - 1'b1;
          if (adj_reg == 4'h1) begin
            state_next = S_USER;
          end
        end
      end
      S_USER: begin
        if (tmr_cnt == TMR_W'(TRACK_CYCLES - 1)) begin
          idx_next = '0;
          state_next = S_SWEEP;
        end
      end
    endcase
    addr_next = addr_reg;
    unique case (state_next)
      S_POA_RD: addr_next = POA_ADDR;
      S_WAS: addr_next = WL_ADDR_FIRST + ADDR_W'(idx_next);
      S_RLAT: addr_next = WL_ADDR_FIRST;
      S_AL_RD: begin
        if (idx_next == '0) begin
          addr_next = WL_ADDR_PRE;
        end else if (idx_next == 4'h1) begin
          addr_next = WL_ADDR_FIRST;
        end else begin
          addr_next = WL_ADDR_POST;
        end
      end
      default: addr_next = addr_reg;
    endcase
  end

  // ----------------------------------------
  // Sequencer registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= S_IDLE;
      idx_reg <= '0;
      rsp_reg <= '0;
      addr_reg <= '0;
      wl_data_reg <= '0;
      rlat_reg <= '0;
      wlat_reg <= '0;
      ac1t_reg <= 1'b0;
      tries_reg <= '0;
      poa_reg <= POA_DLY_MAX;
      smp_reg <= '0;
      ref_reg <= '0;
      drift_reg <= '0;
      adj_reg <= '0;
      adj_up_reg <= 1'b0;
      tracked_reg <= 1'b0;
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      restart_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      rsp_reg <= rsp_next;
      addr_reg <= addr_next;
      wl_data_reg <= wl_data_next;
      rlat_reg <= rlat_next;
      wlat_reg <= wlat_next;
      ac1t_reg <= ac1t_next;
      tries_reg <= tries_next;
      poa_reg <= poa_next;
      smp_reg <= smp_next;
      ref_reg <= ref_next;
      drift_reg <= drift_next;
      adj_reg <= adj_next;
      adj_up_reg <= adj_up_next;
      tracked_reg <= tracked_next;
      done_reg <= done_next;
      fail_reg <= fail_next;
      restart_reg <= restart_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign cmd_valid = (state_reg == S_POA_RD) || (state_reg == S_WAS) ||
                     (state_reg == S_RLAT) || (state_reg == S_AL_RD);
  assign cmd_write = (state_reg == S_WAS);
  assign cmd_addr = addr_reg;
  // Every beat of a word carries the same count
  assign cmd_wdata = {BEATS{lat_cnt}};
  assign doing_rd = (state_reg == S_RLAT) && cmd_ready;
  assign mr_valid = (state_reg == S_MR);
  assign mr_cs = idx_reg[CS_W-1:0];
  assign mr_user = 1'b1;
  assign pll_req = (state_reg == S_STEP) || (state_reg == S_ADJ);
  assign pll_sel_resync = (state_reg == S_ADJ);
  assign pll_up = (state_reg == S_ADJ) ? adj_up_reg : 1'b1;
  assign read_latency = rlat_reg;
  assign write_latency_cycles = wlat_reg;
  assign addr_cmd_1t = ac1t_reg;
  // Gate delay feeds the DQS override in the capture path
  assign poa_delay = poa_reg;
  assign cal_done = done_reg;
  assign cal_fail = fail_reg;
  assign restart_cal = restart_reg;

endmodule : mlct_seq

// ==== mlct_seq_asserts.sv ====
`timescale 1ns/1ns
module mlct_seq_asserts
  import mlct_pkg::*;
#(
  parameter int unsigned TRACK_CYCLES = TRACK_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic dqs_capture,
  input wire logic half_rate,
  input wire logic cal_done,
  input wire logic restart_cal,
  // Command and read path
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_wdata,
  input wire logic doing_rd,
  input wire logic rd_valid,
  // Mode registers and PLL
  input wire logic mr_valid,
  input wire logic mr_user,
  input wire logic pll_req,
  input wire logic pll_sel_resync,
  input wire logic pll_up,
  input wire logic pll_done,
  // Results
  input wire logic [CNT_W-1:0] read_latency,
  input wire logic [4:0] poa_delay
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic arm_reg;
  logic [CNT_W-1:0] cnt_reg;

  // Own latency count, armed only by the latency read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      arm_reg <= 1'b0;
      cnt_reg <= 8'h00;
    end else begin
      arm_reg <= doing_rd | (arm_reg & ~rd_valid);
      cnt_reg <= doing_rd ? 8'h01 : cnt_reg + 8'h01;
    end
  end

  rlat_capture_a: assert property (arm_reg && rd_valid |=> read_latency == $past(cnt_reg))
    else $error("read latency differs from counted cycles");
  doing_rd_read_a: assert property (doing_rd |-> cmd_valid && cmd_ready && !cmd_write
    && cmd_addr == WL_ADDR_FIRST) else $error("doing_rd without latency read");
  cmd_hold_a: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_addr)
    && $stable(cmd_write) && $stable(cmd_wdata)) else $error("command changed before accept");
  wr_pattern_a: assert property (cmd_valid && cmd_write |-> cmd_addr >= WL_ADDR_FIRST
    && cmd_addr <= WL_ADDR_FIRST + 8'h07 && {3{cmd_wdata[7:0]}} == cmd_wdata[31:8])
    else $error("bad latency pattern write");
  poa_skip_a: assert property (cmd_valid && !dqs_capture |-> cmd_addr != POA_ADDR)
    else $error("postamble read without DQS capture");
  poa_step_a: assert property (poa_delay != $past(poa_delay) && poa_delay != POA_DLY_MAX
    |-> poa_delay == $past(poa_delay) - 5'h01) else $error("gate delay not stepped down by one");
  restart_hr_a: assert property (restart_cal |-> half_rate ##1 !restart_cal)
    else $error("restart without half rate or not a pulse");
  mr_user_a: assert property (mr_valid |-> mr_user)
    else $error("user mode register write with overrides");
  pll_hold_a: assert property (pll_req && !pll_done |=> pll_req && $stable(pll_sel_resync)
    && $stable(pll_up)) else $error("phase step request changed early");
  resync_user_a: assert property (pll_req && pll_sel_resync |-> cal_done)
    else $error("resync clock stepped outside user mode");
endmodule : mlct_seq_asserts

bind mlct_seq mlct_seq_asserts #(.TRACK_CYCLES(TRACK_CYCLES)) mlct_seq_asserts_inst (
  .clk(clk), .resetn(resetn), .dqs_capture(dqs_capture), .half_rate(half_rate),
  .cal_done(cal_done), .restart_cal(restart_cal), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
  .doing_rd(doing_rd), .rd_valid(rd_valid), .mr_valid(mr_valid), .mr_user(mr_user),
  .pll_req(pll_req), .pll_sel_resync(pll_sel_resync), .pll_up(pll_up), .pll_done(pll_done),
  .read_latency(read_latency), .poa_delay(poa_delay));
